/* File: logic/rsq_pkg.sv */
package rsq_pkg;

  // Core clock.
  localparam int CLK_PERIOD_NS = 10;

  // Power-up timer: slow internal oscillator periods of nominally 32 us each.
  localparam int PUT_TICK_US = 32;
  localparam int PUT_PERIODS = 2048;
  localparam int PUT_W = 11;
  localparam logic [PUT_W-1:0] PUT_LAST = 11'h7FF;

  // Oscillator start-up timer in main oscillator periods.
  localparam int OSU_PERIODS = 1024;
  localparam int OSU_W = 10;
  localparam logic [OSU_W-1:0] OSU_LAST = 10'h3FF;

  // PLL lock wait and program memory bias wait, least times rounded up.
  localparam int PLL_LOCK_NS = 2000000;
  localparam int PLL_LOCK_CYCLES = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIAS_MIN_NS = 5000;
  localparam int BIAS_MAX_NS = 10000;
  localparam int BIAS_CYCLES = (BIAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_W = 18;

  // Register byte offsets.
  localparam logic [7:0] OFF_CAUSE = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_STACK = 8'h08;
  localparam logic [7:0] OFF_SEQ = 8'h0C;

  // Reset cause control fields.
  localparam int CAUSE_PRIO_EN = 7;
  localparam int FLAG_OPCODE = 4;
  localparam int FLAG_WDOG = 3;
  localparam int FLAG_SLEEP = 2;
  localparam int FLAG_POR = 1;
  localparam int FLAG_BROWN = 0;
  localparam logic [4:0] FLAGS_RESET = 5'h1F;
  localparam logic [4:0] FLAGS_POR = 5'h1C;

  // Configuration register fields.
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_PUT_OFF = 4;
  localparam int CFG_STK_RST = 5;
  localparam logic [7:0] CFG_RESET = 8'h05;

  // Stack status fields.
  localparam int STK_FULL = 7;
  localparam int STK_UNF = 6;

  // Program counter values.
  localparam int PC_W = 21;
  localparam logic [PC_W-1:0] RESET_VECTOR = 21'h000000;
  localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
  localparam logic [PC_W-1:0] VEC_LOW = 21'h000018;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

  typedef enum logic [1:0] {
    PM_FULL = 2'b00,
    PM_RUN = 2'b01,
    PM_IDLE = 2'b10,
    PM_SLEEP = 2'b11
  } rsq_pm_t;

  typedef enum logic [3:0] {
    OSC_LOW_POWER_CRYSTAL = 4'b0000,
    OSC_STD_CRYSTAL = 4'b0001,
    OSC_FAST_CRYSTAL = 4'b0010,
    OSC_FAST_CRYSTAL_X4 = 4'b0011,
    OSC_EXT_CLOCK_GPIO = 4'b0100,
    OSC_EXT_CLOCK = 4'b0101,
    OSC_RESISTOR_CAP = 4'b0110,
    OSC_RESISTOR_CAP_GPIO = 4'b0111,
    OSC_INTERNAL_A = 4'b1000,
    OSC_INTERNAL_B = 4'b1001
  } rsq_osc_t;

  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_PUT = 3'b001,
    ST_OSU = 3'b010,
    ST_PLL = 3'b011,
    ST_BIAS = 3'b100,
    ST_RUN = 3'b101
  } rsq_state_t;

endpackage

/* File: logic/rsq_sync.sv */
`timescale 1ns/10ps
module rsq_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

/* File: logic/rsq_timer.sv */
`timescale 1ns/10ps
module rsq_timer #(
  parameter int W = 11
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic tick,
  input wire logic [W-1:0] last,
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_r;

  // Counts ticks from zero up to last; done pulses the cycle after the final tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      cnt_r <= '0;
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy && tick) begin
      if (cnt_r == last) begin
        busy <= 1'b0;
        done <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
        done <= 1'b0;
      end
    end else begin
      done <= 1'b0;
    end
  end
endmodule

/* File: logic/rsq_top.sv */
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module rsq_top #(
  parameter int PLL_LOCK_CYCLES = rsq_pkg::PLL_LOCK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic por_active,
  input wire logic brownout_active,
  input wire logic ext_reset_pin_n,
  input wire logic slow_osc_clk,
  input wire logic main_osc_clk,
  input wire logic wdt_expiry,
  input wire logic reset_opcode,
  input wire logic stack_overflow,
  input wire logic stack_underflow,
  input wire logic wake_int,
  input wire logic wake_int_high,
  input wire logic high_int_global_enable,
  input wire logic low_int_global_enable,
  input wire logic [1:0] pm_mode,
  input wire logic [20:0] pc_now,
  output logic core_reset_n,
  output logic pc_load,
  output logic [20:0] pc_load_addr,
  output logic stack_clear,
  output logic stack_push,
  output logic wake_hold
);
  logic [4:0] pins_s;
  logic por_s, brown_s, pin_low, slow_s, osc_s;
  logic por_d_r, brown_d_r, pin_d_r, slow_d_r, osc_d_r;
  logic slow_tick, osc_tick;
  rsq_pkg::rsq_state_t state_r, state_nxt;
  logic wake_seq_r, wake_seq_nxt;
  logic wake_vec_r;
  logic [20:0] vec_addr_r;
  logic [7:0] cfg_r;
  logic [4:0] flags_r, flags_nxt;
  logic int_priority_enable_r, stk_full_r, stk_unf_r;
  logic core_reset_n_r, core_reset_n_nxt;
  logic pc_load_r, stack_clear_r, stack_push_r;
  logic [20:0] pc_load_addr_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  rsq_pkg::rsq_osc_t osc_mode;
  logic put_off, stk_rst_en, crystal, x4, rc, lowpwr;
  logic hold, live, ev_por, ev_brown, ev_pin, ev_wdt_rst, ev_wdt_wake, ev_int_wake, ev_op, ev_stk;
  logic int_reset, any_reset, wake_ev, finish, hi_prio, vec_take;
  logic put_start, osu_start, wait_start, put_done, osu_done, wait_done;
  logic [rsq_pkg::WAIT_W-1:0] wait_last;
  logic wr, mapped;
  logic [7:0] rd_byte;

  rsq_sync #(.W(5)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({por_active, brownout_active, ext_reset_pin_n, slow_osc_clk, main_osc_clk}),
    .q(pins_s)
  );

  assign por_s = pins_s[4];
  assign brown_s = pins_s[3];
  assign pin_low = ~pins_s[2];
  assign slow_s = pins_s[1];
  assign osc_s = pins_s[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_d_r <= 1'b0;
      brown_d_r <= 1'b0;
      // The synced pin reads low just after reset; starting high here avoids a false pin event.
      pin_d_r <= 1'b1;
      slow_d_r <= 1'b0;
      osc_d_r <= 1'b0;
    end else begin
      por_d_r <= por_s;
      brown_d_r <= brown_s;
      pin_d_r <= pin_low;
      slow_d_r <= slow_s;
      osc_d_r <= osc_s;
    end
  end

  assign slow_tick = slow_s & ~slow_d_r;
  assign osc_tick = osc_s & ~osc_d_r;

  assign osc_mode = rsq_pkg::rsq_osc_t'(cfg_r[rsq_pkg::CFG_MODE_LSB +: 4]);
  assign put_off = cfg_r[rsq_pkg::CFG_PUT_OFF];
  assign stk_rst_en = cfg_r[rsq_pkg::CFG_STK_RST];
  assign crystal = (osc_mode == rsq_pkg::OSC_LOW_POWER_CRYSTAL) || (osc_mode == rsq_pkg::OSC_STD_CRYSTAL) ||
                   (osc_mode == rsq_pkg::OSC_FAST_CRYSTAL) || (osc_mode == rsq_pkg::OSC_FAST_CRYSTAL_X4);
  assign x4 = (osc_mode == rsq_pkg::OSC_FAST_CRYSTAL_X4);
  assign rc = (osc_mode == rsq_pkg::OSC_RESISTOR_CAP) || (osc_mode == rsq_pkg::OSC_RESISTOR_CAP_GPIO);
  assign lowpwr = (pm_mode == rsq_pkg::PM_IDLE) || (pm_mode == rsq_pkg::PM_SLEEP);

  // Events are made mutually exclusive here, highest cause first.
  assign hold = por_s | brown_s;
  assign ev_por = por_s & ~por_d_r;
  assign ev_brown = brown_s & ~brown_d_r & ~por_s;
  assign ev_pin = pin_low & ~pin_d_r & ~hold;
  assign live = (state_r == rsq_pkg::ST_RUN) & ~wake_seq_r & ~hold & ~pin_low;
  assign ev_wdt_rst = live & wdt_expiry & ~lowpwr;
  assign ev_wdt_wake = live & wdt_expiry & lowpwr;
  assign ev_int_wake = live & wake_int & lowpwr & ~wdt_expiry;
  assign ev_op = live & reset_opcode & ~lowpwr & ~wdt_expiry;
  assign ev_stk = live & stk_rst_en & (stack_overflow | stack_underflow) & ~lowpwr & ~wdt_expiry & ~reset_opcode;
  assign int_reset = ev_wdt_rst | ev_op | ev_stk;
  assign any_reset = ev_por | ev_brown | ev_pin | int_reset;
  assign wake_ev = ev_wdt_wake | ev_int_wake;
  // Without priority levels every interrupt takes the high vector.
  assign hi_prio = wake_int_high | ~int_priority_enable_r;
  assign vec_take = ev_int_wake & (hi_prio ? high_int_global_enable : low_int_global_enable);

  always_comb begin
    state_nxt = state_r;
    wake_seq_nxt = wake_seq_r;
    if (hold) begin
      state_nxt = rsq_pkg::ST_HOLD;
      wake_seq_nxt = 1'b0;
    end else begin
      case (state_r)
        rsq_pkg::ST_HOLD: begin
          if (!put_off) begin
            state_nxt = rsq_pkg::ST_PUT;
          end else if (crystal) begin
            state_nxt = rsq_pkg::ST_OSU;
          end else if (rc) begin
            state_nxt = rsq_pkg::ST_RUN;
          end else begin
            state_nxt = rsq_pkg::ST_BIAS;
          end
        end
        rsq_pkg::ST_PUT: begin
          if (put_done) begin
            state_nxt = crystal ? rsq_pkg::ST_OSU : rsq_pkg::ST_RUN;
          end
        end
        rsq_pkg::ST_OSU: begin
          if (osu_done) begin
            state_nxt = x4 ? rsq_pkg::ST_PLL : rsq_pkg::ST_RUN;
          end
        end
        rsq_pkg::ST_PLL: begin
          if (wait_done) begin
            state_nxt = rsq_pkg::ST_RUN;
          end
        end
        rsq_pkg::ST_BIAS: begin
          if (wait_done) begin
            state_nxt = rsq_pkg::ST_RUN;
          end
        end
        rsq_pkg::ST_RUN: begin
          if (wake_ev) begin
            wake_seq_nxt = 1'b1;
            state_nxt = crystal ? rsq_pkg::ST_OSU : rsq_pkg::ST_BIAS;
          end
        end
        default: begin
          state_nxt = rsq_pkg::ST_HOLD;
        end
      endcase
      // A wake ends when the core runs again, so live events are accepted afterwards.
      if (state_nxt == rsq_pkg::ST_RUN) begin
        wake_seq_nxt = 1'b0;
      end
      if (ev_pin) begin
        wake_seq_nxt = 1'b0;
      end
    end
  end

  assign finish = (state_nxt == rsq_pkg::ST_RUN) && (state_r != rsq_pkg::ST_RUN) && !hold;
  // The reset pin only gates the core; it never restarts the delays.
  assign core_reset_n_nxt = !hold && !pin_low && !int_reset &&
                            ((state_nxt == rsq_pkg::ST_RUN) || wake_seq_nxt);

  assign put_start = (state_nxt == rsq_pkg::ST_PUT) && (state_r != rsq_pkg::ST_PUT);
  assign osu_start = (state_nxt == rsq_pkg::ST_OSU) && (state_r != rsq_pkg::ST_OSU);
  assign wait_start = ((state_nxt == rsq_pkg::ST_PLL) && (state_r != rsq_pkg::ST_PLL)) ||
                      ((state_nxt == rsq_pkg::ST_BIAS) && (state_r != rsq_pkg::ST_BIAS));
  assign wait_last = (state_nxt == rsq_pkg::ST_PLL) ? rsq_pkg::WAIT_W'(PLL_LOCK_CYCLES - 1) :
                     rsq_pkg::WAIT_W'(rsq_pkg::BIAS_CYCLES - 1);

  rsq_timer #(.W(rsq_pkg::PUT_W)) u_put (
    .pclk(pclk),
    .presetn(presetn),
    .start(put_start),
    .tick(slow_tick),
    .last(rsq_pkg::PUT_LAST),
    .busy(),
    .done(put_done)
  );

  rsq_timer #(.W(rsq_pkg::OSU_W)) u_osu (
    .pclk(pclk),
    .presetn(presetn),
    .start(osu_start),
    .tick(osc_tick),
    .last(rsq_pkg::OSU_LAST),
    .busy(),
    .done(osu_done)
  );

  rsq_timer #(.W(rsq_pkg::WAIT_W)) u_wait (
    .pclk(pclk),
    .presetn(presetn),
    .start(wait_start),
    .tick(1'b1),
    .last(wait_last),
    .busy(),
    .done(wait_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= rsq_pkg::ST_HOLD;
      wake_seq_r <= 1'b0;
      core_reset_n_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wake_seq_r <= wake_seq_nxt;
      core_reset_n_r <= core_reset_n_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_vec_r <= 1'b0;
      vec_addr_r <= rsq_pkg::VEC_HIGH;
    end else if (wake_ev) begin
      wake_vec_r <= vec_take;
      vec_addr_r <= hi_prio ? rsq_pkg::VEC_HIGH : rsq_pkg::VEC_LOW;
    end
  end

  // Restart address and stack latch control.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_load_r <= 1'b0;
      pc_load_addr_r <= rsq_pkg::RESET_VECTOR;
      stack_clear_r <= 1'b0;
      stack_push_r <= 1'b0;
    end else if (any_reset) begin
      pc_load_r <= 1'b1;
      pc_load_addr_r <= rsq_pkg::RESET_VECTOR;
      stack_clear_r <= 1'b1;
      stack_push_r <= 1'b0;
    end else if (finish && wake_seq_r) begin
      pc_load_r <= 1'b1;
      pc_load_addr_r <= wake_vec_r ? vec_addr_r : pc_now + rsq_pkg::PC_STEP;
      stack_clear_r <= 1'b0;
      stack_push_r <= wake_vec_r;
    end else if (finish) begin
      pc_load_r <= 1'b1;
      pc_load_addr_r <= rsq_pkg::RESET_VECTOR;
      stack_clear_r <= 1'b1;
      stack_push_r <= 1'b0;
    end else begin
      pc_load_r <= 1'b0;
      stack_clear_r <= 1'b0;
      stack_push_r <= 1'b0;
    end
  end

  assign wr = psel && penable && pwrite && pready_r;

  // Hardware events override a software write in the same cycle.
  always_comb begin
    flags_nxt = flags_r;
    if (wr && (paddr == rsq_pkg::OFF_CAUSE)) begin
      flags_nxt = pwdata[4:0];
    end
    if (ev_por) begin
      flags_nxt = rsq_pkg::FLAGS_POR;
    end else if (ev_brown) begin
      flags_nxt[rsq_pkg::FLAG_OPCODE] = 1'b1;
      flags_nxt[rsq_pkg::FLAG_WDOG] = 1'b1;
      flags_nxt[rsq_pkg::FLAG_SLEEP] = 1'b1;
      flags_nxt[rsq_pkg::FLAG_BROWN] = 1'b0;
    end else if (ev_pin) begin
      flags_nxt[rsq_pkg::FLAG_WDOG] = 1'b1;
      if (lowpwr) begin
        flags_nxt[rsq_pkg::FLAG_SLEEP] = 1'b0;
      end
    end else if (ev_wdt_rst) begin
      flags_nxt[rsq_pkg::FLAG_WDOG] = 1'b0;
    end else if (ev_wdt_wake) begin
      flags_nxt[rsq_pkg::FLAG_WDOG] = 1'b0;
      flags_nxt[rsq_pkg::FLAG_SLEEP] = 1'b0;
    end else if (ev_int_wake) begin
      flags_nxt[rsq_pkg::FLAG_SLEEP] = 1'b0;
    end else if (ev_op) begin
      flags_nxt[rsq_pkg::FLAG_OPCODE] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= rsq_pkg::FLAGS_RESET;
      int_priority_enable_r <= 1'b0;
      cfg_r <= rsq_pkg::CFG_RESET;
    end else begin
      flags_r <= flags_nxt;
      if (wr && (paddr == rsq_pkg::OFF_CAUSE)) begin
        int_priority_enable_r <= pwdata[rsq_pkg::CAUSE_PRIO_EN];
      end
      if (wr && (paddr == rsq_pkg::OFF_CFG)) begin
        cfg_r <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stk_full_r <= 1'b0;
      stk_unf_r <= 1'b0;
    end else if (ev_por) begin
      stk_full_r <= 1'b0;
      stk_unf_r <= 1'b0;
    end else begin
      stk_full_r <= stack_overflow | ((wr && (paddr == rsq_pkg::OFF_STACK)) ? pwdata[rsq_pkg::STK_FULL] : stk_full_r);
      stk_unf_r <= stack_underflow | ((wr && (paddr == rsq_pkg::OFF_STACK)) ? pwdata[rsq_pkg::STK_UNF] : stk_unf_r);
    end
  end

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      rsq_pkg::OFF_CAUSE: rd_byte = {int_priority_enable_r, 2'h0, flags_r};
      rsq_pkg::OFF_CFG: rd_byte = cfg_r;
      rsq_pkg::OFF_STACK: rd_byte = {stk_full_r, stk_unf_r, 6'h00};
      rsq_pkg::OFF_SEQ: rd_byte = {3'h0, wake_seq_r, core_reset_n_r, state_r};
      default: begin
        rd_byte = 8'h00;
        mapped = 1'b0;
      end
    endcase
  end

  // Zero wait states: answer is ready in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= psel && !penable;
      pslverr_r <= psel && !penable && !mapped;
      prdata_r <= (psel && !penable && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign core_reset_n = core_reset_n_r;
  assign pc_load = pc_load_r;
  assign pc_load_addr = pc_load_addr_r;
  assign stack_clear = stack_clear_r;
  assign stack_push = stack_push_r;
  assign wake_hold = wake_seq_r;

  // Helper counters watched only by the checks below.
  logic [10:0] osu_ticks_r;
  logic [9:0] bias_cyc_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osu_ticks_r <= 11'h000;
      bias_cyc_r <= 10'h000;
    end else begin
      osu_ticks_r <= (state_r == rsq_pkg::ST_OSU) ? osu_ticks_r + 11'(osc_tick) : 11'h000;
      bias_cyc_r <= (state_r == rsq_pkg::ST_BIAS) ? bias_cyc_r + 10'h001 : 10'h000;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_put_then_osu: assert property ((state_r == rsq_pkg::ST_PUT) && put_done && crystal && !hold
    |=> state_r == rsq_pkg::ST_OSU) else $error("oscillator wait did not follow power-up timer");
  a_rc_no_delay: assert property ((state_r == rsq_pkg::ST_HOLD) && !hold && put_off && rc
    |=> state_r == rsq_pkg::ST_RUN) else $error("rc mode without timer did not leave reset directly");
  a_pin_release: assert property ((state_r == rsq_pkg::ST_RUN) && !wake_seq_r && $fell(pin_low) && !hold && !int_reset
    |=> core_reset_n_r) else $error("core not released at pin release");
  a_put_skipped: assert property ((state_r == rsq_pkg::ST_HOLD) && !hold && put_off
    |=> state_r != rsq_pkg::ST_PUT) else $error("power-up timer ran while disabled");
  a_osu_length: assert property ((state_r == rsq_pkg::ST_OSU) && osu_done
    |-> osu_ticks_r == 11'(rsq_pkg::OSU_PERIODS)) else $error("oscillator wait length wrong");
  a_pll_after_osu: assert property ((state_r == rsq_pkg::ST_OSU) && osu_done && x4 && !hold
    |=> state_r == rsq_pkg::ST_PLL) else $error("pll wait missing");
  a_bias_length: assert property ((state_r == rsq_pkg::ST_BIAS) && wait_done
    |-> bias_cyc_r == 10'(rsq_pkg::BIAS_CYCLES)) else $error("bias wait length wrong");
  a_por_flags: assert property (ev_por
    |=> flags_r == rsq_pkg::FLAGS_POR && !stk_full_r && !stk_unf_r && pc_load_r &&
        pc_load_addr_r == rsq_pkg::RESET_VECTOR) else $error("power-on flags wrong");
  a_wdt_run_reset: assert property (ev_wdt_rst
    |=> !flags_r[rsq_pkg::FLAG_WDOG] && !core_reset_n_r && pc_load_r) else $error("watchdog reset wrong");
  a_wdt_wake: assert property (ev_wdt_wake
    |=> !flags_r[rsq_pkg::FLAG_WDOG] && !flags_r[rsq_pkg::FLAG_SLEEP] && core_reset_n_r)
    else $error("watchdog wake wrong");
  a_wake_vector: assert property (finish && wake_seq_r && wake_vec_r
    |=> pc_load_r && stack_push_r && pc_load_addr_r == $past(vec_addr_r)) else $error("wake vector not loaded");
  a_core_held: assert property ((state_r != rsq_pkg::ST_RUN) && !wake_seq_r
    |-> !core_reset_n_r) else $error("core released during delays");

  c_pll_boot: cover property ((state_r == rsq_pkg::ST_PLL) ##1 (state_r == rsq_pkg::ST_RUN));
  c_vector_wake: cover property (ev_int_wake && vec_take);
  c_pin_late: cover property ((state_r == rsq_pkg::ST_RUN) && pin_low ##1 !pin_low);
endmodule

/* File: tb/rsq_far.sv */
`timescale 1ns/10ps
module rsq_far (
  input wire logic pclk,
  input wire logic por_req,
  input wire logic pin_req,
  output logic por_active,
  output logic brownout_active,
  output logic ext_reset_pin_n,
  output logic slow_osc_clk,
  output logic main_osc_clk
);
  // Both oscillators run at a quarter of the core rate so their edges can be counted.
  logic [1:0] div_r = 2'h0;
  always @(posedge pclk) begin
    div_r <= div_r + 2'h1;
  end
  assign slow_osc_clk = div_r[1];
  assign main_osc_clk = div_r[1];
  assign por_active = por_req;
  assign ext_reset_pin_n = ~pin_req;
  assign brownout_active = 1'b0;
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, por_req = 1'b0, pin_req = 1'b0, gie = 1'b0;
  logic por_active, brownout_active, ext_reset_pin_n, slow_osc_clk, main_osc_clk;
  logic [4:0] ev = 5'h00;
  logic [1:0] pm = 2'h0;
  logic core_reset_n, pc_load, stack_clear, stack_push, wake_hold;
  logic [20:0] pc_load_addr;
  int bad_count = 0, total_checks = 0;
  always #5 pclk = ~pclk;
  rsq_far i_rsq_far (.pclk(pclk), .por_req(por_req), .pin_req(pin_req), .por_active(por_active),
    .brownout_active(brownout_active), .ext_reset_pin_n(ext_reset_pin_n), .slow_osc_clk(slow_osc_clk),
    .main_osc_clk(main_osc_clk));
  rsq_top #(.PLL_LOCK_CYCLES(20)) i_rsq_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .por_active(por_active), .brownout_active(brownout_active), .ext_reset_pin_n(ext_reset_pin_n),
    .slow_osc_clk(slow_osc_clk), .main_osc_clk(main_osc_clk), .wdt_expiry(ev[0]), .reset_opcode(ev[1]),
    .stack_overflow(ev[2]), .stack_underflow(ev[3]), .wake_int(ev[4]), .wake_int_high(1'b1),
    .high_int_global_enable(gie), .low_int_global_enable(1'b0), .pm_mode(pm), .pc_now(21'h001234),
    .core_reset_n(core_reset_n), .pc_load(pc_load), .pc_load_addr(pc_load_addr), .stack_clear(stack_clear),
    .stack_push(stack_push), .wake_hold(wake_hold));
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A read compares the error flag and data together against e.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", 1'b1, pready);
    if (!w) chk("read", e, {pslverr, prdata});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_run(output int n);
    n = 0;
    while (core_reset_n !== 1'b1 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic t_por(input logic [7:0] c, input logic p, input int lo, input int hi);
    int n;
    apb(1'b1, 8'h04, {24'h0, c}, 33'h0);
    por_req <= 1'b1;
    pin_req <= p;
    repeat (6) @(posedge pclk);
    chk("core_reset_n", 1'b0, core_reset_n);
    por_req <= 1'b0;
    if (p) begin
      repeat (2000) @(posedge pclk);
      chk("core_reset_n", 1'b0, core_reset_n);
      pin_req <= 1'b0;
    end
    wait_run(n);
    chk("delay", 1'b1, n >= lo && n <= hi);
    apb(1'b0, 8'h00, 32'h0, 33'h01C);
    $display("power-on test %h done", c);
  endtask
  task automatic t_evt(input int b, input logic rst, input logic [7:0] a, input logic [32:0] e);
    ev[b] <= 1'b1;
    @(posedge pclk);
    ev <= 5'h00;
    @(posedge pclk);
    chk("core_reset_n", !rst, core_reset_n);
    chk("pc_load", rst, pc_load);
    chk("stack_clear", rst, stack_clear);
    if (rst) chk("pc_load_addr", 33'h0, pc_load_addr);
    @(posedge pclk);
    chk("core_reset_n", 1'b1, core_reset_n);
    apb(1'b0, a, 32'h0, e);
    $display("event test %0d done", b);
  endtask
  task automatic t_wake(input int b, input logic [1:0] m, input logic g, input logic [20:0] pa, input logic [32:0] f);
    int n;
    pm <= m;
    gie <= g;
    ev[b] <= 1'b1;
    @(posedge pclk);
    ev <= 5'h00;
    @(posedge pclk);
    chk("wake_hold", 1'b1, wake_hold & core_reset_n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pc_load !== 1'b1 && n < 2000);
    chk("wake_delay", 1'b1, n >= 498 && n <= 1000);
    chk("pc_load_addr", pa, pc_load_addr);
    chk("stack_push", g, stack_push);
    chk("wake_hold", 1'b0, wake_hold);
    pm <= 2'h0;
    apb(1'b0, 8'h00, 32'h0, f);
    $display("wake test %0d done", b);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    int n;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    wait_run(n);
    chk("put_delay", 1'b1, n >= 8180 && n <= 8230);
    apb(1'b0, 8'h00, 32'h0, 33'h01F);
    apb(1'b0, 8'h04, 32'h0, 33'h005);
    apb(1'b0, 8'h10, 32'h0, 33'h100000000);
    t_por(8'h16, 1'b0, 0, 12);
    t_por(8'h06, 1'b0, 8180, 8230);
    t_por(8'h11, 1'b0, 4080, 4130);
    t_por(8'h13, 1'b0, 4100, 4150);
    t_por(8'h15, 1'b1, 0, 8);
    t_evt(1, 1'b1, 8'h00, 33'h0C);
    t_evt(0, 1'b1, 8'h00, 33'h04);
    t_evt(3, 1'b0, 8'h08, 33'h40);
    apb(1'b1, 8'h04, 32'h35, 33'h0);
    t_evt(2, 1'b1, 8'h08, 33'hC0);
    apb(1'b1, 8'h08, 32'h0, 33'h0);
    t_evt(3, 1'b1, 8'h08, 33'h40);
    apb(1'b1, 8'h00, 32'h1F, 33'h0);
    t_wake(4, 2'h3, 1'b1, 21'h000008, 33'h1B);
    t_wake(4, 2'h2, 1'b0, 21'h001236, 33'h1B);
    t_wake(0, 2'h3, 1'b0, 21'h001236, 33'h13);
    pm <= 2'h3;
    pin_req <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("core_reset_n", 1'b0, core_reset_n);
    pin_req <= 1'b0;
    pm <= 2'h0;
    wait_run(n);
    chk("pin_delay", 1'b1, n < 20000);
    apb(1'b0, 8'h00, 32'h0, 33'h1B);
    $display("pin test done");
    complete_run;
  end
  initial begin
    #900000;
    bad_count++;
    complete_run;
  end
endmodule
